// [design/pefu_defines.vh]
// Register offsets, bit positions and reset values of the event flag unit.
// Assumes an 8-bit register port driven by the serial control interface.
// Behaviour
// - Die-temperature flags (bits 5..2) set on threshold crossing either way.
// - Flag group 0 bit 1 sets on a supply low-voltage event.
// - Flag group 0 bit 0 sets on the turn-on event.
// - Flags clear only by writing 1 or by reset; writing 0 leaves them unchanged.
// - Each flag register has a mask register, same positions, 1 masks.
// - Unmasked flags drive the interrupt pin; masked flags never do.
// - Mask group 0 bits 5..2 temperature, bit 1 low-voltage, bit 0 power-on.
// - Sense register at 0x07 shows present conditions without latching.
// - Sense bit 7 shows the fuse-programming supply pin level.
// - Sense bits 5..2 read 1 while die temperature is above threshold.
// - Sense bit 1 reads 1 while the supply input is below 2.7 V.
// - Sense bit 0 follows the enable pin level.
// - Sense bits reset to 0; once synchronised they show the monitored condition.
// - Sense register bit 6 always reads 0.
// - Flag group 1 bits 4, 3, 1, 0 latch regulator overcurrent events.
// - Mask group 1 has mask bits at 4, 3, 1, 0; 1 masks.
`ifndef PEFU_DEFINES_VH
`define PEFU_DEFINES_VH

`define PEFU_ADDR_SENSE0   8'h07
`define PEFU_ADDR_FLAGS0   8'h05
`define PEFU_ADDR_MASK0    8'h06
`define PEFU_ADDR_FLAGS1   8'h08
`define PEFU_ADDR_MASK1    8'h09

`define PEFU_G0_IMPL       8'h3f
`define PEFU_G1_IMPL       8'h1b
`define PEFU_MASK0_RST     8'h3f
`define PEFU_MASK1_RST     8'h1b
`define PEFU_FLAGS_RST     8'h00

`define PEFU_BIT_FUSE      7
`define PEFU_BIT_TEMP_HI   5
`define PEFU_BIT_TEMP_LO   2
`define PEFU_BIT_UNDERV    1
`define PEFU_BIT_ENABLE    0

`endif

// [design/pefu_sync.v]
// Three-stage input synchroniser with agreement filter.
// Assumes the input comes from a pin outside the clk_sys domain.
`timescale 1ns/100ps
`include "pefu_defines.vh"
module pefu_sync (
	clk_sys,
	rst,
	async_in,
	level_out,
	valid_out
);
	input  wire       clk_sys;
	input  wire       rst;
	input  wire       async_in;
	output reg        level_out;
	output reg        valid_out;

	reg        s1_r;
	reg        s2_r;
	reg        s3_r;
	reg  [2:0] fill_r;

	// Level updates only when the second and third stages agree
	// Fill chain keeps reset zeros in the stages from passing as a level
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_r      <= 1'b0;
			s2_r      <= 1'b0;
			s3_r      <= 1'b0;
			fill_r    <= 3'b000;
			level_out <= 1'b0;
			valid_out <= 1'b0;
		end else begin
			s1_r   <= async_in;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			fill_r <= {fill_r[1:0], 1'b1};
			if (fill_r[2] && (s2_r == s3_r)) begin
				level_out <= s3_r;
				valid_out <= 1'b1;
			end
		end
	end
endmodule

// [design/pefu_event_bit.v]
// One latched event flag with write-1-to-clear and set priority.
// Assumes set_evt and clr_wr come from logic on clk_sys.
`timescale 1ns/100ps
`include "pefu_defines.vh"
module pefu_event_bit (
	clk_sys,
	rst,
	set_evt,
	clr_wr,
	flag_r
);
	input  wire       clk_sys;
	input  wire       rst;
	input  wire       set_evt;
	input  wire       clr_wr;
	output reg        flag_r;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_r <= 1'b0;
		end else if (set_evt) begin
			flag_r <= 1'b1;
		end else if (clr_wr) begin
			flag_r <= 1'b0;
		end
	end
endmodule

// [design/pefu_top.v]
// Event flag, mask and sense logic of the power-management control port.
// Assumes an 8-bit register port from the serial control interface on
// clk_sys; condition inputs are asynchronous levels from analog monitors.
`timescale 1ns/100ps
`include "pefu_defines.vh"
module pefu_top (
	clk_sys,
	rst,
	reg_addr,
	reg_wr,
	reg_rd,
	reg_wdata,
	reg_rdata,
	temp_above_thr,
	input_undervolt,
	enable_pin,
	fuse_program_supply_pin,
	turn_on_evt,
	buck_overcurrent,
	irq_out_n
);
	input  wire       clk_sys;
	input  wire       rst;
	input  wire [7:0] reg_addr;
	input  wire       reg_wr;
	input  wire       reg_rd;
	input  wire [7:0] reg_wdata;
	output reg  [7:0] reg_rdata;
	input  wire [3:0] temp_above_thr;
	input  wire       input_undervolt;
	input  wire       enable_pin;
	input  wire       fuse_program_supply_pin;
	input  wire       turn_on_evt;
	input  wire [2:0] buck_overcurrent;
	output reg        irq_out_n;

	// Synchronised live conditions: [0] enable, [1] undervolt,
	// [5:2] temperature, [6] fuse supply, [7] turn-on,
	// [8] buck1, [9] buck2, [10] buck3
	wire [10:0] raw_in;
	wire [10:0] live;
	wire [10:0] live_ok;
	reg  [10:0] live_d_r;
	reg  [10:0] seen_r;

	assign raw_in = {buck_overcurrent, turn_on_evt,
		fuse_program_supply_pin, temp_above_thr,
		input_undervolt, enable_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
			pefu_sync u_pefu_sync (
				.clk_sys   (clk_sys),
				.rst       (rst),
				.async_in  (raw_in[gi]),
				.level_out (live[gi]),
				.valid_out (live_ok[gi])
			);
		end
	endgenerate

	// Edge history primed once each input has settled after reset
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			live_d_r <= 11'h000;
			seen_r   <= 11'h000;
		end else begin
			live_d_r <= live;
			seen_r   <= live_ok;
		end
	end

	wire [10:0] rise;
	wire [10:0] chg;
	assign rise = live & ~live_d_r & seen_r;
	assign chg  = (live ^ live_d_r) & seen_r;

	wire [7:0] set0;
	wire [7:0] set1;
	assign set0 = {2'b00, chg[5:2], rise[1], rise[7]};
	// Flag group 1: buck3 bit 4, buck2 bit 3, buck1 bits 1 and 0
	assign set1 = {3'b000, live[10], live[9], 1'b0,
		live[8], live[8]} & `PEFU_G1_IMPL;

	wire wr_flags0;
	wire wr_flags1;
	wire wr_mask0;
	wire wr_mask1;
	assign wr_flags0 = reg_wr && (reg_addr == `PEFU_ADDR_FLAGS0);
	assign wr_flags1 = reg_wr && (reg_addr == `PEFU_ADDR_FLAGS1);
	assign wr_mask0  = reg_wr && (reg_addr == `PEFU_ADDR_MASK0);
	assign wr_mask1  = reg_wr && (reg_addr == `PEFU_ADDR_MASK1);

	wire [7:0] clr0;
	wire [7:0] clr1;
	assign clr0 = wr_flags0 ? reg_wdata : 8'h00;
	assign clr1 = wr_flags1 ? reg_wdata : 8'h00;

	wire [15:0] flags;
	wire [15:0] sets;
	wire [15:0] clrs;
	assign sets = {set1, set0};
	assign clrs = {clr1, clr0};

	genvar fi;
	generate
		for (fi = 0; fi < 16; fi = fi + 1) begin : g_flag
			pefu_event_bit u_pefu_event_bit (
				.clk_sys (clk_sys),
				.rst     (rst),
				.set_evt (sets[fi]),
				.clr_wr  (clrs[fi]),
				.flag_r  (flags[fi])
			);
		end
	endgenerate

	wire [7:0] flags0;
	wire [7:0] flags1;
	assign flags0 = flags[7:0] & `PEFU_G0_IMPL;
	assign flags1 = flags[15:8] & `PEFU_G1_IMPL;

	reg  [7:0] mask0_r;
	reg  [7:0] mask1_r;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask0_r <= `PEFU_MASK0_RST;
			mask1_r <= `PEFU_MASK1_RST;
		end else begin
			if (wr_mask0)
				mask0_r <= reg_wdata & `PEFU_G0_IMPL;
			if (wr_mask1)
				mask1_r <= reg_wdata & `PEFU_G1_IMPL;
		end
	end

	// Live sense view, unlatched
	wire [7:0] sense0;
	assign sense0 = {live[6], 1'b0, live[5:2], live[1], live[0]};

	wire irq_any;
	assign irq_any = |(flags0 & ~mask0_r) | |(flags1 & ~mask1_r);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= ~irq_any;
		end
	end

	reg  [7:0] rdata_nxt;
	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`PEFU_ADDR_SENSE0: rdata_nxt = sense0;
			`PEFU_ADDR_FLAGS0: rdata_nxt = flags0;
			`PEFU_ADDR_MASK0:  rdata_nxt = mask0_r;
			`PEFU_ADDR_FLAGS1: rdata_nxt = flags1;
			`PEFU_ADDR_MASK1:  rdata_nxt = mask1_r;
			default:           rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end
endmodule

// [verification/pefu_monitor.sv]
// Port checker for the event flag unit.
// Assumes a bind into pefu_top; read data lands one edge after reg_rd.
`timescale 1ns/100ps
module pefu_monitor (
	input wire       clk_sys,
	input wire       rst,
	input wire [7:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire [3:0] temp_above_thr,
	input wire       input_undervolt,
	input wire       enable_pin,
	input wire       fuse_program_supply_pin,
	input wire       irq_out_n
);
	wire [7:0] ra = reg_rd ? reg_addr : 8'hff;
	wire [7:0] sense_exp = {fuse_program_supply_pin, 1'b0, temp_above_thr,
		input_undervolt, enable_pin};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_rst_idle: assert property ($fell(rst) |-> irq_out_n && !reg_rdata)
		else $error("outputs not idle after reset");
	a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_rd_unmapped: assert property (ra == 8'h00 |=> !reg_rdata)
		else $error("unmapped read not zero");
	a_sense_live: assert property (
		$stable(sense_exp) [*7] ##0 ra == 8'h07
		|=> reg_rdata == $past(sense_exp))
		else $error("sense does not show conditions");
	a_flags0_bits: assert property (ra == 8'h05 |=> !reg_rdata[7:6])
		else $error("flags0 unused bits set");
	a_mask0_bits: assert property (ra == 8'h06 |=> !reg_rdata[7:6])
		else $error("mask0 unused bits set");
	a_flags1_bits: assert property (ra == 8'h08 |=> !(reg_rdata & 8'he4))
		else $error("flags1 unused bits set");
	a_mask1_bits: assert property (ra == 8'h09 |=> !(reg_rdata & 8'he4))
		else $error("mask1 unused bits set");
endmodule

bind pefu_top pefu_monitor u_pefu_monitor (.clk_sys, .rst, .reg_addr,
	.reg_rd, .reg_rdata, .temp_above_thr, .input_undervolt, .enable_pin,
	.fuse_program_supply_pin, .irq_out_n);

// [verification/pefu_host_model.sv]
// Host processor model on the register port.
// Assumes one-cycle strobes taken at the rising edge.
`timescale 1ns/100ps
module pefu_host_model (
	input  wire       clk_sys,
	output reg  [7:0] reg_addr = 8'h00,
	output reg        reg_wr = 1'b0,
	output reg        reg_rd = 1'b0,
	output reg  [7:0] reg_wdata = 8'h00,
	input  wire [7:0] reg_rdata
);
	// Any order; strobes of consecutive calls are one idle cycle apart
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~v;
		end
	endtask
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			#1 v = reg_rdata;
		end
	endtask
endmodule

// [verification/pefu_top_bench.sv]
// Self-checking bench of the event flag unit.
// Assumes the host model owns the register port.
`timescale 1ns/100ps
module pefu_top_bench;
	reg         clk_sys = 1'b0;
	reg         rst = 1'b1;
	reg  [10:0] cond = 11'h410;
	wire [7:0]  reg_addr;
	wire [7:0]  reg_wdata;
	wire [7:0]  reg_rdata;
	wire        reg_wr;
	wire        reg_rd;
	wire        irq_out_n;
	integer     n_errors = 0;
	integer     comparisons = 0;
	reg  [7:0]  d;
	always #4 clk_sys = ~clk_sys;
	pefu_host_model u_pefu_host_model (.clk_sys, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata);
	pefu_top u_pefu_top (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .temp_above_thr(cond[9:6]),
		.input_undervolt(cond[5]), .enable_pin(cond[4]),
		.fuse_program_supply_pin(cond[10]), .turn_on_evt(cond[3]),
		.buck_overcurrent(cond[2:0]), .irq_out_n);
	// Item ff is the interrupt pin, others are register offsets
	function string item_name(input [7:0] id);
		case (id)
			8'h05:   item_name = "flags0";
			8'h06:   item_name = "mask0";
			8'h07:   item_name = "sense0";
			8'h08:   item_name = "flags1";
			8'h09:   item_name = "mask1";
			8'hff:   item_name = "irq_out_n";
			default: item_name = "unmapped";
		endcase
	endfunction
	task chk(input [7:0] s, input [7:0] e, input [7:0] id);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				n_errors = n_errors + 1;
				$display("[ERR] %s exp %h seen %h", item_name(id), e, s);
			end
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			u_pefu_host_model.rd(a, d);
			chk(d, e, a);
		end
	endtask
	task w(input [7:0] a, input [7:0] v);
		u_pefu_host_model.wr(a, v);
	endtask
	task ci(input e);
		begin
			repeat (2) @(posedge clk_sys);
			#1 chk({7'h0, irq_out_n}, {7'h0, e}, 8'hff);
		end
	endtask
	task put(input [10:0] v);
		begin
			@(posedge clk_sys) cond <= v;
			repeat (8) @(posedge clk_sys);
		end
	endtask
	task t_reset;
		begin
			repeat (6) @(posedge clk_sys);
			rc(8'h07, 8'h81);
			rc(8'h05, 8'h00);
			rc(8'h06, 8'h3f);
			rc(8'h09, 8'h1b);
			rc(8'h00, 8'h00);
			$display("t_reset done");
		end
	endtask
	task t_sense;
		begin
			put(11'h3e0);
			rc(8'h07, 8'h3e);
			w(8'h07, 8'hff);
			rc(8'h07, 8'h3e);
			put(11'h410);
			rc(8'h07, 8'h81);
			$display("t_sense done");
		end
	endtask
	task t_flags;
		begin
			w(8'h05, 8'hff);
			w(8'h08, 8'hff);
			rc(8'h05, 8'h00);
			put(11'h450);
			rc(8'h05, 8'h04);
			w(8'h05, 8'h00);
			rc(8'h05, 8'h04);
			w(8'h05, 8'h04);
			put(11'h410);
			rc(8'h05, 8'h04);
			put(11'h438);
			rc(8'h05, 8'h07);
			ci(1'b1);
			w(8'h06, 8'h3e);
			ci(1'b0);
			w(8'h05, 8'h07);
			ci(1'b1);
			$display("t_flags done");
		end
	endtask
	task t_oc;
		begin
			put(11'h43f);
			rc(8'h08, 8'h1b);
			w(8'h08, 8'hff);
			rc(8'h08, 8'h1b);
			put(11'h43a);
			w(8'h08, 8'hff);
			rc(8'h08, 8'h08);
			w(8'h09, 8'h13);
			ci(1'b0);
			put(11'h438);
			w(8'h08, 8'hff);
			ci(1'b1);
			$display("t_oc done");
		end
	endtask
	// Levels held high across a reset must not look like fresh events
	task t_rst_mid;
		begin
			w(8'h06, 8'h00);
			@(posedge clk_sys) rst <= 1'b1;
			repeat (2) @(posedge clk_sys);
			rst <= 1'b0;
			repeat (8) @(posedge clk_sys);
			rc(8'h05, 8'h00);
			rc(8'h06, 8'h3f);
			rc(8'h07, 8'h83);
			ci(1'b1);
			$display("t_rst_mid done");
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d comparisons %0d", n_errors, comparisons);
			if (n_errors == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_sense;
		t_flags;
		t_oc;
		t_rst_mid;
		stop_test;
	end
	initial begin
		#20000;
		n_errors = n_errors + 1;
		stop_test;
	end
endmodule
